// File: logic/smp_in_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module smp_in_sync
   import smp_pkg::*;
(
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic async_in,
   output logic      level
);

   smp_sync_type r;
   smp_sync_type n;

   // First stage feeds only the second; the filter looks at stages two and three
   always_comb begin
      n     = r;
      n.s1  = async_in;
      n.s2  = r.s1;
      n.s3  = r.s2;
      if (r.s2 == r.s3) begin
         n.lvl = r.s3;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= SMP_SYNC_RESET;
      end else begin
         r <= n;
      end
   end

   assign level = r.lvl;

endmodule

// File: logic/smp_master_port.sv
// Serial master port: APB registers, clock generator and byte shifter
// Function
// R01: Two rate select bits choose one of four serial clock rates.
// R02: Idle level and sample phase bits pick one of four timing modes.
// R03: Data register write loads the shifter and sends the byte MSB first.
// R04: Hardware sets the done flag when a byte transfer completes.
// R05: Interrupt fires on done only if enabled and processor mask clear.
// R06: Received byte is copied to a buffer on completion; data reads return it.
// R07: Done flag clears by flags access while set, then data read.
// R08: Data writes are ignored while done is set until flags are read.
// R09: Each transfer shifts out and in together over eight clock pulses.
// R10: Serial clock rests at the idle level whenever no transfer runs.
// R11: Phase set: capture on second edge, falling if idle low.
// R12: Phase clear: capture on first edge, rising if idle low.
// R13: Each output bit is on the pin before its capture edge.
// R14: Slave select comes from elsewhere; this port has none.
// R15: Writing data during a transfer sets the write clash flag.
// R16: The write clash flag never raises the interrupt.
// R17: Write clash clears by flags read then data read.
// R18: Three pins: serial in, serial out and serial clock out.
// R19: Sample on capture edge, change output on the opposite edge.
// R20: A blocked data write changes neither shifter nor receive buffer.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/100ps
module smp_master_port
   import smp_pkg::*;
(
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire smp_apb_req_type  apb_req,
   output logic [31:0]           prdata,
   output logic                  pready,
   output logic                  pslverr,
   input  wire logic             cpu_irq_mask,
   input  wire logic             serial_in_pin,
   output logic                  serial_out_pin,
   output logic                  serial_clk_pin,
   output logic                  xfer_irq
);

   smp_state_type r;
   smp_state_type n;
   logic          sin;
   logic          setup;
   logic          acc;
   logic          wr_data;
   logic          rd_data;
   logic          rd_flags;
   logic          wr_cfg;
   logic          half_tick;
   logic          lead;
   logic          cap;
   logic          launch;
   logic          busy;
   logic          blocked;

   smp_in_sync u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (serial_in_pin),
      .level    (sin)
   );

   // Register index: 0 unmapped, 1 data, 2 config, 3 flags
   function automatic logic [1:0] smp_decode(input logic [7:0] a);
      case (a)
         SMP_OFS_DATA:   smp_decode = 2'h1;
         SMP_OFS_CONFIG: smp_decode = 2'h2;
         SMP_OFS_FLAGS:  smp_decode = 2'h3;
         default:        smp_decode = 2'h0;
      endcase
   endfunction

   // Reload value of the half period counter
   function automatic logic [5:0] smp_half_load(input logic [1:0] rate);
      case (rate)
         2'h0:    smp_half_load = 6'(SMP_HALF_CYC_0 - 1);
         2'h1:    smp_half_load = 6'(SMP_HALF_CYC_1 - 1);
         2'h2:    smp_half_load = 6'(SMP_HALF_CYC_2 - 1);
         default: smp_half_load = 6'(SMP_HALF_CYC_3 - 1);
      endcase
   endfunction

   // No wait state: pready rises in the setup cycle's wake
   assign setup     = apb_req.psel & ~apb_req.penable;
   assign acc       = apb_req.psel & apb_req.penable & r.pready;
   assign wr_data   = acc & apb_req.pwrite
                    & (smp_decode(apb_req.paddr) == 2'h1);
   assign rd_data   = acc & ~apb_req.pwrite
                    & (smp_decode(apb_req.paddr) == 2'h1);
   assign wr_cfg    = acc & apb_req.pwrite
                    & (smp_decode(apb_req.paddr) == 2'h2);
   assign rd_flags  = acc & (smp_decode(apb_req.paddr) == 2'h3);
   assign half_tick = (r.half_cnt == 6'h00);
   assign lead      = ~r.edge_cnt[0];
   assign busy      = (r.phase != SMP_IDLE);
   assign blocked   = r.done & ~r.arm_done;
   // Phase clear captures on leading edges, phase set on trailing ones
   assign cap       = r.cfg.sample_phase ? ~lead : lead; // [R11] [R12]
   assign launch    = r.cfg.sample_phase ? lead
                    : (~lead & (r.edge_cnt != SMP_LAST_EDGE)); // [R19]

   always_comb begin
      n         = r;
      n.pready  = 1'b0;
      n.pslverr = 1'b0;

      if (setup) begin
         n.pready  = 1'b1;
         n.pslverr = (smp_decode(apb_req.paddr) == 2'h0);
         case (smp_decode(apb_req.paddr))
            2'h1:    n.prdata = {24'h000000, r.rx_buf}; // [R06]
            2'h2:    n.prdata = {27'h0000000, r.cfg};
            2'h3: begin
               n.prdata = 32'h00000000;
               n.prdata[SMP_FLG_DONE_POS]  = r.done;
               n.prdata[SMP_FLG_CLASH_POS] = r.clash;
               n.prdata[SMP_FLG_BUSY_POS]  = busy;
            end
            default: n.prdata = 32'h00000000;
         endcase
      end

      if (wr_cfg) begin
         n.cfg.rate_sel[0]  = apb_req.pwdata[SMP_CFG_RATE_LO_POS]; // [R01]
         n.cfg.rate_sel[1]  = apb_req.pwdata[SMP_CFG_RATE_HI_POS]; // [R01]
         n.cfg.sample_phase = apb_req.pwdata[SMP_CFG_PHASE_POS]; // [R02]
         n.cfg.idle_level   = apb_req.pwdata[SMP_CFG_IDLE_POS]; // [R02]
         n.cfg.irq_en       = apb_req.pwdata[SMP_CFG_IRQEN_POS];
      end

      // Clear sequence: a flags access arms, a later data read clears
      if (rd_flags) begin
         n.arm_done  = r.arm_done | r.done; // [R07]
         n.arm_clash = r.arm_clash | r.clash; // [R17]
      end
      if (rd_data && r.arm_done) begin
         n.done     = 1'b0; // [R07]
         n.arm_done = 1'b0;
      end
      if (rd_data && r.arm_clash) begin
         n.clash     = 1'b0; // [R17]
         n.arm_clash = 1'b0;
      end

      if (wr_data) begin
         if (busy) begin
            // The running byte is left alone; only the flag records it
            n.clash = 1'b1; // [R15]
         end else if (!blocked) begin // [R08] [R20]
            n.phase    = SMP_RUN; // [R03]
            n.half_cnt = smp_half_load(r.cfg.rate_sel); // [R01]
            n.edge_cnt = 4'h0;
            if (r.cfg.sample_phase) begin
               n.tx_sh = apb_req.pwdata[7:0];
            end else begin
               // MSB goes out a half period before the first edge
               n.sout  = apb_req.pwdata[7]; // [R13]
               n.tx_sh = {apb_req.pwdata[6:0], 1'b0}; // [R03]
            end
         end
      end

      case (r.phase)
         SMP_IDLE: begin
            n.sck = r.cfg.idle_level; // [R10]
         end
         SMP_RUN: begin
            if (half_tick) begin
               n.half_cnt = smp_half_load(r.cfg.rate_sel);
               n.sck      = ~r.sck; // [R09] [R18]
               n.edge_cnt = 4'(r.edge_cnt + 4'h1);
               if (cap) begin
                  n.rx_sh = {r.rx_sh[6:0], sin}; // [R19]
               end
               if (launch) begin
                  n.sout  = r.tx_sh[7]; // [R03] [R13]
                  n.tx_sh = {r.tx_sh[6:0], 1'b0};
               end
               if (r.edge_cnt == SMP_LAST_EDGE) begin
                  n.phase = SMP_TAIL; // [R09]
               end
            end else begin
               n.half_cnt = 6'(r.half_cnt - 6'h01);
            end
         end
         SMP_TAIL: begin
            // Hold the last bit a half period after the final edge
            if (half_tick) begin
               n.phase  = SMP_IDLE;
               n.done   = 1'b1; // [R04]
               n.rx_buf = r.rx_sh; // [R06]
            end else begin
               n.half_cnt = 6'(r.half_cnt - 6'h01);
            end
         end
         default: begin
            n.phase = SMP_IDLE;
         end
      endcase

      // The clash flag is deliberately kept out of this term
      n.irq = n.done & n.cfg.irq_en & ~cpu_irq_mask; // [R05] [R16]
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= SMP_STATE_RESET;
      end else begin
         r <= n;
      end
   end

   assign prdata         = r.prdata;
   assign pready         = r.pready;
   assign pslverr        = r.pslverr;
   assign serial_out_pin = r.sout;
   assign serial_clk_pin = r.sck;
   assign xfer_irq       = r.irq;

   default clocking smp_cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_idle_level;
      r.phase == SMP_IDLE |=> r.sck == $past(r.cfg.idle_level);
   endproperty
   a_idle_level: assert property (p_idle_level) // [R10]
      else $error("Serial clock not at idle level");

   property p_complete;
      (r.phase == SMP_TAIL) && half_tick
         |=> r.done && (r.rx_buf == $past(r.rx_sh))
             && (r.phase == SMP_IDLE);
   endproperty
   a_complete: assert property (p_complete) // [R04]
      else $error("Completion did not set flag and buffer");

   property p_irq;
      r.done && r.cfg.irq_en && !cpu_irq_mask && !rd_data && !wr_cfg
         |=> r.irq;
   endproperty
   a_irq: assert property (p_irq) // [R05]
      else $error("Interrupt missing on completion");

   property p_no_clash_irq;
      r.irq |-> r.done && r.cfg.irq_en && !$past(cpu_irq_mask);
   endproperty
   a_no_clash_irq: assert property (p_no_clash_irq) // [R16]
      else $error("Interrupt without completion");

   property p_blocked;
      wr_data && !busy && blocked
         |=> (r.phase == SMP_IDLE) && $stable(r.tx_sh)
             && $stable(r.rx_buf);
   endproperty
   a_blocked: assert property (p_blocked) // [R08]
      else $error("Blocked write started a transfer");

   property p_clash;
      // On a half tick the running byte shifts by itself, so skip those
      wr_data && busy && !half_tick
         |=> r.clash && $stable(r.tx_sh) && $stable(r.edge_cnt);
   endproperty
   a_clash: assert property (p_clash) // [R15]
      else $error("Write during transfer did not set clash");

   property p_done_clear;
      $fell(r.done) |-> $past(rd_data) && $past(r.arm_done);
   endproperty
   a_done_clear: assert property (p_done_clear) // [R07]
      else $error("Done flag cleared without the sequence");

   property p_clash_clear;
      $fell(r.clash) |-> $past(rd_data) && $past(r.arm_clash);
   endproperty
   a_clash_clear: assert property (p_clash_clear) // [R17]
      else $error("Clash flag cleared without the sequence");

   property p_start;
      wr_data && !busy && !blocked && !r.cfg.sample_phase
         |=> (r.phase == SMP_RUN) && (r.edge_cnt == 4'h0)
             && (r.sout == $past(apb_req.pwdata[7]));
   endproperty
   a_start: assert property (p_start) // [R03]
      else $error("Write did not start the byte MSB first");

   property p_edge;
      (r.phase == SMP_RUN) && half_tick
         |=> (r.sck != $past(r.sck))
             && (r.half_cnt == smp_half_load(r.cfg.rate_sel));
   endproperty
   a_edge: assert property (p_edge) // [R09]
      else $error("Serial clock edge or reload wrong");

   property p_capture;
      (r.phase == SMP_RUN) && half_tick && cap
         |=> r.rx_sh[0] == $past(sin);
   endproperty
   a_capture: assert property (p_capture) // [R12]
      else $error("Input not captured on the capture edge");

   property p_last_edge;
      (r.phase == SMP_RUN) && half_tick && (r.edge_cnt == SMP_LAST_EDGE)
         |=> (r.phase == SMP_TAIL) && (r.sck == r.cfg.idle_level);
   endproperty
   a_last_edge: assert property (p_last_edge) // [R09]
      else $error("Clock not idle after sixteenth edge");

endmodule

// File: logic/smp_pkg.sv
// Constants, field layouts and state types of the serial master port
package smp_pkg;

   localparam logic [7:0] SMP_OFS_DATA   = 8'h04;
   localparam logic [7:0] SMP_OFS_CONFIG = 8'h08;
   localparam logic [7:0] SMP_OFS_FLAGS  = 8'h0c;

   // Config register bit positions
   localparam int SMP_CFG_RATE_LO_POS = 0;
   localparam int SMP_CFG_RATE_HI_POS = 1;
   localparam int SMP_CFG_PHASE_POS   = 2;
   localparam int SMP_CFG_IDLE_POS    = 3;
   localparam int SMP_CFG_IRQEN_POS   = 4;

   // Flags register bit positions
   localparam int SMP_FLG_BUSY_POS  = 0;
   localparam int SMP_FLG_CLASH_POS = 6;
   localparam int SMP_FLG_DONE_POS  = 7;

   localparam logic [7:0] SMP_CFG_RESET  = 8'h00;
   localparam logic [7:0] SMP_DATA_RESET = 8'h00;

   // Serial clock half periods per rate selection
   localparam int SMP_CLK_PERIOD_NS = 5;
   localparam int SMP_HALF_NS_0     = 40;
   localparam int SMP_HALF_NS_1     = 80;
   localparam int SMP_HALF_NS_2     = 160;
   localparam int SMP_HALF_NS_3     = 320;
   localparam int SMP_HALF_CYC_0    = SMP_HALF_NS_0 / SMP_CLK_PERIOD_NS;
   localparam int SMP_HALF_CYC_1    = SMP_HALF_NS_1 / SMP_CLK_PERIOD_NS;
   localparam int SMP_HALF_CYC_2    = SMP_HALF_NS_2 / SMP_CLK_PERIOD_NS;
   localparam int SMP_HALF_CYC_3    = SMP_HALF_NS_3 / SMP_CLK_PERIOD_NS;

   // Eight pulses make sixteen edges, numbered 0 to 15
   localparam logic [3:0] SMP_LAST_EDGE = 4'hf;

   typedef enum logic [1:0] {SMP_IDLE, SMP_RUN, SMP_TAIL} smp_phase_type;

   typedef struct packed {
      logic [7:0]  paddr;
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] pwdata;
   } smp_apb_req_type;

   typedef struct packed {
      logic       irq_en;
      logic       idle_level;
      logic       sample_phase;
      logic [1:0] rate_sel;
   } smp_cfg_type;

   typedef struct packed {
      smp_phase_type phase;
      smp_cfg_type   cfg;
      logic [7:0]    tx_sh;
      logic [7:0]    rx_sh;
      logic [7:0]    rx_buf;
      logic [5:0]    half_cnt;
      logic [3:0]    edge_cnt;
      logic          sck;
      logic          sout;
      logic          done;
      logic          clash;
      logic          arm_done;
      logic          arm_clash;
      logic          irq;
      logic [31:0]   prdata;
      logic          pready;
      logic          pslverr;
   } smp_state_type;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
   } smp_sync_type;

   localparam smp_state_type SMP_STATE_RESET = '0;
   localparam smp_sync_type  SMP_SYNC_RESET  = '0;

endpackage

// File: tb/smp_slave_model.sv
// Behavioural serial slave that answers the master port
`timescale 1ns/100ps
module smp_slave_model (
   input  wire logic       sck,
   input  wire logic       sout,
   input  wire logic       sel,
   input  wire logic       idle_level,
   input  wire logic       sample_phase,
   input  wire logic       slow,
   input  wire logic [7:0] tx_byte,
   output logic            sin,
   output logic [7:0]      rx_byte
);
   logic [7:0] sh_reg;

   // Late answers probe how much data valid delay the master tolerates
   task automatic emit();
      sin <= #(slow ? 10 : 1) sh_reg[7];
      sh_reg = {sh_reg[6:0], 1'b0};
   endtask

   initial begin
      sin = 1'b0;
      rx_byte = 8'h00;
      sh_reg = 8'h00;
   end

   // Select comes from the bench, standing in for a general purpose pin
   always @(posedge sel) begin
      sh_reg = tx_byte;
      if (!sample_phase)
         emit();
   end

   // Released line shows the inverse so no stale bit passes for data
   always @(negedge sel)
      sin <= ~sin;

   always @(sck) begin
      if (sel) begin
         if ((sck != idle_level) ^ sample_phase)
            rx_byte = {rx_byte[6:0], sout};
         else
            emit();
      end
   end
endmodule

// File: tb/testbench.sv
// Self-checking bench for the serial master port
`timescale 1ns/100ps
module testbench;
   import smp_pkg::*;
   logic            pclk;
   logic            presetn;
   smp_apb_req_type req;
   logic [31:0]     prdata;
   logic            pready;
   logic            pslverr;
   logic            cpu_irq_mask;
   logic            serial_in_pin;
   logic            serial_out_pin;
   logic            serial_clk_pin;
   logic            xfer_irq;
   logic            sel, idle_lvl, phase, slow, err, sck_q;
   logic [7:0]      slv_tx, slv_rx, tx;
   logic [31:0]     rd, cfg;
   int              n_mismatch, compares, edges, half, run;
   int              half_tab [4];

   smp_master_port uut (
      .pclk(pclk), .presetn(presetn), .apb_req(req), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cpu_irq_mask(cpu_irq_mask),
      .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
      .serial_clk_pin(serial_clk_pin), .xfer_irq(xfer_irq));

   smp_slave_model slave (
      .sck(serial_clk_pin), .sout(serial_out_pin), .sel(sel),
      .idle_level(idle_lvl), .sample_phase(phase), .slow(slow),
      .tx_byte(slv_tx), .sin(serial_in_pin), .rx_byte(slv_rx));

   always #2.5 pclk = ~pclk;

   // Count serial clock edges and the cycles between the last two
   always @(posedge pclk) begin
      if (serial_clk_pin !== sck_q) begin
         edges++;
         half = run;
         run = 1;
      end else
         run++;
      sck_q = serial_clk_pin;
   end

   task automatic check(input string name, input logic [31:0] seen,
                        input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic test_done();
      $display("Compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // One idle cycle before each setup keeps every strobe single-driven
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
      int n;
      @(posedge pclk);
      req.paddr <= a;
      req.pwrite <= wr;
      req.pwdata <= wd;
      req.psel <= 1'b1;
      @(posedge pclk);
      req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         n_mismatch++;
         test_done();
      end
      rd = prdata;
      err = pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask

   initial begin
      #100000;
      n_mismatch++;
      test_done();
   end

   initial begin
      half_tab = '{SMP_HALF_CYC_0, SMP_HALF_CYC_1, SMP_HALF_CYC_2,
                   SMP_HALF_CYC_3};
      pclk = 1'b0;
      presetn = 1'b0;
      req = '0;
      cpu_irq_mask = 1'b0;
      {sel, idle_lvl, phase, slow, sck_q} = '0;
      slv_tx = 8'h00;
      {n_mismatch, compares, edges, half, run} = '0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, SMP_OFS_CONFIG, 32'h0);
      check("config reset", rd, 32'(SMP_CFG_RESET));
      apb(1'b0, SMP_OFS_DATA, 32'h0);
      check("data reset", rd, 32'(SMP_DATA_RESET));
      apb(1'b1, SMP_OFS_FLAGS, 32'hff);
      apb(1'b0, SMP_OFS_FLAGS, 32'h0);
      check("flags read only", rd, 32'h0);
      apb(1'b0, 8'h10, 32'h0);
      check("unmapped error", 32'(err), 32'h1);
      check("unmapped data", rd, 32'h0);
      check("idle clock reset", 32'(serial_clk_pin), 32'h0);
      for (int i = 0; i < 4; i++) begin
         idle_lvl = i[1];
         phase = i[0];
         slow = i[0];
         slv_tx = 8'h3a + 8'(i);
         tx = 8'h96 ^ 8'(i);
         cpu_irq_mask <= (i == 3);
         cfg = (32'(i != 2) << SMP_CFG_IRQEN_POS) |
               (32'(i[1]) << SMP_CFG_IDLE_POS) |
               (32'(i[0]) << SMP_CFG_PHASE_POS) | 32'(i);
         apb(1'b1, SMP_OFS_CONFIG, cfg);
         apb(1'b0, SMP_OFS_CONFIG, 32'h0);
         check("config", rd, cfg);
         repeat (4) @(posedge pclk);
         check("idle clock", 32'(serial_clk_pin), 32'(i[1]));
         sel = 1'b1;
         edges = 0;
         apb(1'b1, SMP_OFS_DATA, 32'(tx));
         apb(1'b0, SMP_OFS_FLAGS, 32'h0);
         check("busy", rd, 32'h1 << SMP_FLG_BUSY_POS);
         apb(1'b1, SMP_OFS_DATA, 32'(~tx));
         apb(1'b0, SMP_OFS_FLAGS, 32'h0);
         check("clash", rd, 32'h41);
         check("no clash irq", 32'(xfer_irq), 32'h0);
         // The transfer takes seventeen half periods from its start
         repeat (17 * half_tab[i] + 4) @(posedge pclk);
         check("irq", 32'(xfer_irq), 32'(i < 2));
         apb(1'b1, SMP_OFS_DATA, 32'h5a);
         apb(1'b0, SMP_OFS_FLAGS, 32'h0);
         check("done flags", rd, 32'hc0);
         check("edges", 32'(edges), 32'd16);
         check("half period", 32'(half), 32'(half_tab[i]));
         check("slave rx", 32'(slv_rx), 32'(tx));
         apb(1'b0, SMP_OFS_DATA, 32'h0);
         check("rx buffer", rd, 32'(slv_tx));
         apb(1'b0, SMP_OFS_FLAGS, 32'h0);
         check("flags cleared", rd, 32'h0);
         check("irq cleared", 32'(xfer_irq), 32'h0);
         check("idle after", 32'(serial_clk_pin), 32'(i[1]));
         sel = 1'b0;
      end
      test_done();
   end
endmodule
